// file: design/tcu_timer.sv
// 16-bit timer with five capture/compare units behind an APB slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
module tcu_timer (
   input wire logic pclk,                                 // APB and timer clock
   input wire logic presetn,                              // Asynchronous reset
   input wire tcu_pkg::tcu_apb_req_t apb_req,             // APB request
   output logic [31:0] prdata,                            // Read data
   output logic pready,                                   // Always ready in access
   output logic pslverr,                                  // Unmapped or unaligned
   input wire logic external_timer_clock_pin,             // External timer clock
   input wire logic aux_clock,                            // Auxiliary clock
   input wire logic [tcu_pkg::TCU_UNITS-1:0] event_in,    // Capture event inputs
   output logic [tcu_pkg::TCU_UNITS-1:0] unit_out,        // Output stage pins
   output logic irq_unit0,                                // Unit 0 interrupt
   output logic irq_shared                                // Shared interrupt
);
   import tcu_pkg::*;

   localparam int N = TCU_UNITS;

   tcu_timer_ctl_t tctl_reg;
   tcu_unit_ctl_t uctl_reg [N];
   logic [15:0] val_reg [N];
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic down_reg;
   logic down_next;
   logic [2:0] div_reg;
   logic [N-1:0] out_reg;
   logic [31:0] prdata_reg;

   logic [1:0] ext_sync;
   logic [1:0] aux_sync;
   logic [N-1:0] evt_s1;
   logic [N-1:0] evt_s2;
   logic ext_prev;
   logic aux_prev;
   logic [N-1:0] cap_prev;

   logic src_tick;
   logic tick;
   logic wrap;
   logic [N-1:0] cap_sig;
   logic [N-1:0] cap_evt;
   logic [N-1:0] equ;
   logic [N:1] pend;
   logic [15:0] vector;
   logic wr;
   logic rd;
   logic setup;
   logic [8:0] idx;
   logic hit;

   // Returns the unit whose register of the given base lies at idx, or N if none
   function automatic int unsigned unit_at(input logic [8:0] base, input logic [8:0] a);
      int unsigned u;
      u = N;
      for (int k = 0; k < N; k++) begin
         if (a == base + 9'(2 * k)) begin
            u = k;
         end
      end
      return u;
   endfunction : unit_at

   // Output stage response to compare events of this unit and of unit 0
   function automatic logic out_step(input logic [2:0] m, input logic ob, input logic cur,
                                     input logic eq, input logic eq0);
      logic r;
      r = cur;
      case (m)
         3'h0: r = ob;
         3'h1: r = eq ? 1'b1 : cur;
         3'h2: r = eq0 ? 1'b0 : (eq ? ~cur : cur);
         3'h3: r = eq0 ? 1'b0 : (eq ? 1'b1 : cur);
         3'h4: r = eq ? ~cur : cur;
         3'h5: r = eq ? 1'b0 : cur;
         3'h6: r = eq0 ? 1'b1 : (eq ? ~cur : cur);
         3'h7: r = eq0 ? 1'b1 : (eq ? 1'b0 : cur);
         default: r = cur;
      endcase
      return r;
   endfunction : out_step

   // APB decode
   assign setup = apb_req.psel && !apb_req.penable;
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && hit;
   assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite && hit;
   assign idx = apb_req.paddr[TCU_ADDR_W-1:2];

   always_comb begin
      hit = 1'b0;
      if (apb_req.paddr[1:0] == 2'b00) begin
         hit = (idx == TCU_IDX_VECTOR) || (idx == TCU_IDX_TIMER_CTL)
            || (idx == TCU_IDX_COUNT) || (unit_at(TCU_IDX_UNIT0_CTL, idx) != N)
            || (unit_at(TCU_IDX_UNIT0_VAL, idx) != N);
      end
   end

   assign pready = 1'b1;
   assign pslverr = apb_req.psel && apb_req.penable && !hit;
   assign prdata = prdata_reg;

   // Pin synchronisers; only the second stage is read by logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_sync <= 2'b00;
         aux_sync <= 2'b00;
         evt_s1 <= '0;
         evt_s2 <= '0;
      end else begin
         ext_sync <= {ext_sync[0], external_timer_clock_pin};
         aux_sync <= {aux_sync[0], aux_clock};
         evt_s1 <= event_in;
         evt_s2 <= evt_s1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev <= 1'b0;
         aux_prev <= 1'b0;
      end else begin
         ext_prev <= ext_sync[1];
         aux_prev <= aux_sync[1];
      end
   end

   // Source clock select, then prescaler
   always_comb begin
      case (tctl_reg.clk_src)
         TCU_SRC_EXT_PIN: src_tick = ext_sync[1] && !ext_prev;
         TCU_SRC_AUX: src_tick = aux_sync[1] && !aux_prev;
         default: src_tick = 1'b1;
      endcase
   end

   // Stopped mode freezes the prescaler too, so no count advances
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 3'h0;
      end else if (tctl_reg.clear) begin
         div_reg <= 3'h0;
      end else if (src_tick && tctl_reg.mode != TCU_MODE_STOP) begin
         div_reg <= div_reg + 3'h1;
      end
   end

   always_comb begin
      case (tctl_reg.divider)
         2'h0: tick = 1'b1;
         2'h1: tick = div_reg[0];
         2'h2: tick = &div_reg[1:0];
         default: tick = &div_reg;
      endcase
      tick = tick && src_tick && tctl_reg.mode != TCU_MODE_STOP;
   end

   // Counter next state; up mode wraps at the unit 0 value, continuous mode at ffff
   always_comb begin
      count_next = count_reg;
      down_next = down_reg;
      wrap = 1'b0;
      if (tick) begin
         case (tctl_reg.mode)
            TCU_MODE_UP: begin
               if (count_reg >= val_reg[0]) begin
                  count_next = 16'h0000;
                  wrap = 1'b1;
               end else begin
                  count_next = count_reg + 16'h0001;
               end
            end
            TCU_MODE_CONT: begin
               count_next = count_reg + 16'h0001;
               wrap = (count_reg == 16'hffff);
            end
            TCU_MODE_UPDOWN: begin
               if (!down_reg) begin
                  if (count_reg >= val_reg[0]) begin
                     down_next = 1'b1;
                     count_next = count_reg - 16'h0001;
                     wrap = (count_reg == 16'h0000);
                  end else begin
                     count_next = count_reg + 16'h0001;
                  end
               end else if (count_reg == 16'h0001 || count_reg == 16'h0000) begin
                  count_next = 16'h0000;
                  down_next = 1'b0;
                  wrap = 1'b1;
               end else begin
                  count_next = count_reg - 16'h0001;
               end
            end
            default: count_next = count_reg;
         endcase
      end
   end

   // One counter shared by all units
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= TCU_COUNT_RST;
         down_reg <= 1'b0;
      end else if (wr && idx == TCU_IDX_COUNT) begin
         count_reg <= apb_req.pwdata[15:0];
      end else if (tctl_reg.clear) begin
         count_reg <= TCU_COUNT_RST;
         down_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         down_reg <= down_next;
      end
   end

   // Capture source and edge detection per unit
   always_comb begin
      for (int i = 0; i < N; i++) begin
         case (uctl_reg[i].cap_sel)
            TCU_CIS_EVENT: cap_sig[i] = evt_s2[i];
            TCU_CIS_AUX: cap_sig[i] = aux_sync[1];
            default: cap_sig[i] = uctl_reg[i].cap_sel[0];
         endcase
         case (uctl_reg[i].cap_edge)
            TCU_EDGE_RISE: cap_evt[i] = cap_sig[i] && !cap_prev[i];
            TCU_EDGE_FALL: cap_evt[i] = !cap_sig[i] && cap_prev[i];
            TCU_EDGE_BOTH: cap_evt[i] = cap_sig[i] != cap_prev[i];
            default: cap_evt[i] = 1'b0;
         endcase
         cap_evt[i] = cap_evt[i] && uctl_reg[i].cap_mode;
         equ[i] = tick && !uctl_reg[i].cap_mode && count_next == val_reg[i];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_prev <= '0;
      end else begin
         cap_prev <= cap_sig;
      end
   end

   // Shared vector: unit 1 highest, overflow lowest; even values suit a jump table
   always_comb begin
      for (int i = 1; i < N; i++) begin
         pend[i] = uctl_reg[i].flag && uctl_reg[i].ie;
      end
      pend[N] = tctl_reg.ovf_flag && tctl_reg.ovf_ie;
      vector = TCU_VEC_NONE;
      for (int i = N; i >= 1; i--) begin
         if (pend[i]) begin
            vector = (i == N) ? TCU_VEC_OVERFLOW : 16'(i) * TCU_VEC_STEP;
         end
      end
   end

   assign irq_unit0 = uctl_reg[0].flag && uctl_reg[0].ie;
   assign irq_shared = |pend;

   // Timer control; hardware set of the overflow flag wins over software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tctl_reg <= TCU_TIMER_CTL_RST;
      end else begin
         if (wr && idx == TCU_IDX_TIMER_CTL) begin
            tctl_reg <= tcu_timer_ctl_t'(apb_req.pwdata[15:0]);
            tctl_reg.rsvd <= '0;
            tctl_reg.rsvd3 <= 1'b0;
         end else begin
            tctl_reg.clear <= 1'b0;
            // Clear the event that software was shown, not one raised since setup
            if (rd && idx == TCU_IDX_VECTOR && prdata_reg[15:0] == TCU_VEC_OVERFLOW) begin
               tctl_reg.ovf_flag <= 1'b0;
            end
         end
         if (wrap && !tctl_reg.clear) begin
            tctl_reg.ovf_flag <= 1'b1;
         end
      end
   end

   // Unit control and value registers; capture and compare events win over clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < N; i++) begin
            uctl_reg[i] <= TCU_UNIT_CTL_RST;
            val_reg[i] <= TCU_UNIT_VAL_RST;
         end
      end else begin
         for (int i = 0; i < N; i++) begin
            uctl_reg[i].cap_in <= cap_sig[i];
            if (wr && unit_at(TCU_IDX_UNIT0_CTL, idx) == i) begin
               uctl_reg[i] <= tcu_unit_ctl_t'(apb_req.pwdata[15:0]);
               uctl_reg[i].rsvd <= '0;
               uctl_reg[i].cap_in <= cap_sig[i];
            end else if (rd && idx == TCU_IDX_VECTOR && i != 0
                         && prdata_reg[15:0] == 16'(i) * TCU_VEC_STEP) begin
               uctl_reg[i].flag <= 1'b0;
            end
            if (wr && unit_at(TCU_IDX_UNIT0_VAL, idx) == i) begin
               val_reg[i] <= apb_req.pwdata[15:0];
            end
            if (cap_evt[i]) begin
               val_reg[i] <= count_reg;
               uctl_reg[i].flag <= 1'b1;
               // A second capture before software cleared the flag loses data
               if (uctl_reg[i].flag) begin
                  uctl_reg[i].cap_ovf <= 1'b1;
               end
            end
            if (equ[i]) begin
               uctl_reg[i].flag <= 1'b1;
            end
         end
      end
   end

   // Output stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_reg <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            out_reg[i] <= out_step(uctl_reg[i].out_mode, uctl_reg[i].out_bit, out_reg[i],
                                   equ[i], equ[0]);
         end
      end
   end

   assign unit_out = out_reg;

   // Read data is latched in the setup cycle so prdata comes from a flip-flop
   // Refused reads, unaligned ones included, leave it at zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup && !apb_req.pwrite) begin
         prdata_reg <= 32'h0000_0000;
         if (hit && idx == TCU_IDX_VECTOR) begin
            prdata_reg[15:0] <= vector;
         end else if (hit && idx == TCU_IDX_TIMER_CTL) begin
            prdata_reg[15:0] <= tctl_reg;
         end else if (hit && idx == TCU_IDX_COUNT) begin
            prdata_reg[15:0] <= count_reg;
         end else if (hit) begin
            for (int i = 0; i < N; i++) begin
               if (unit_at(TCU_IDX_UNIT0_CTL, idx) == i) begin
                  prdata_reg[15:0] <= uctl_reg[i];
               end
               if (unit_at(TCU_IDX_UNIT0_VAL, idx) == i) begin
                  prdata_reg[15:0] <= val_reg[i];
               end
            end
         end
      end
   end
endmodule : tcu_timer

// file: design/tcu_pkg.sv
// Register map, field layouts and reset values of the capture/compare timer
package tcu_pkg;
   localparam int TCU_ADDR_W = 11;
   localparam int TCU_UNITS = 5;
   // Printed offsets are register indices; byte address is four times the index
   localparam logic [8:0] TCU_IDX_VECTOR = 9'h12e;
   localparam logic [8:0] TCU_IDX_TIMER_CTL = 9'h160;
   localparam logic [8:0] TCU_IDX_UNIT0_CTL = 9'h162;
   localparam logic [8:0] TCU_IDX_UNIT1_CTL = 9'h164;
   localparam logic [8:0] TCU_IDX_UNIT2_CTL = 9'h166;
   localparam logic [8:0] TCU_IDX_UNIT3_CTL = 9'h168;
   localparam logic [8:0] TCU_IDX_UNIT4_CTL = 9'h16a;
   localparam logic [8:0] TCU_IDX_COUNT = 9'h170;
   localparam logic [8:0] TCU_IDX_UNIT0_VAL = 9'h172;
   localparam logic [8:0] TCU_IDX_UNIT1_VAL = 9'h174;
   localparam logic [8:0] TCU_IDX_UNIT2_VAL = 9'h176;
   localparam logic [8:0] TCU_IDX_UNIT3_VAL = 9'h178;
   localparam logic [8:0] TCU_IDX_UNIT4_VAL = 9'h17a;
   // Clock source select codes
   localparam logic [1:0] TCU_SRC_EXT_PIN = 2'h0;
   localparam logic [1:0] TCU_SRC_AUX = 2'h1;
   // Counting modes
   localparam logic [1:0] TCU_MODE_STOP = 2'h0;
   localparam logic [1:0] TCU_MODE_UP = 2'h1;
   localparam logic [1:0] TCU_MODE_CONT = 2'h2;
   localparam logic [1:0] TCU_MODE_UPDOWN = 2'h3;
   // Capture input select codes
   localparam logic [1:0] TCU_CIS_EVENT = 2'h0;
   localparam logic [1:0] TCU_CIS_AUX = 2'h1;
   // Capture edge codes
   localparam logic [1:0] TCU_EDGE_RISE = 2'h1;
   localparam logic [1:0] TCU_EDGE_FALL = 2'h2;
   localparam logic [1:0] TCU_EDGE_BOTH = 2'h3;
   // Vector word values for the shared events
   localparam logic [15:0] TCU_VEC_NONE = 16'h0000;
   localparam logic [15:0] TCU_VEC_STEP = 16'h0002;
   localparam logic [15:0] TCU_VEC_OVERFLOW = 16'h000a;
   // Reset values
   localparam logic [15:0] TCU_TIMER_CTL_RST = 16'h0000;
   localparam logic [15:0] TCU_UNIT_CTL_RST = 16'h0000;
   localparam logic [15:0] TCU_COUNT_RST = 16'h0000;
   localparam logic [15:0] TCU_UNIT_VAL_RST = 16'h0000;

   typedef struct packed {
      logic [5:0] rsvd;        // 15:10
      logic [1:0] clk_src;     // 9:8
      logic [1:0] divider;     // 7:6
      logic [1:0] mode;        // 5:4
      logic rsvd3;             // 3
      logic clear;             // 2, self clearing
      logic ovf_ie;            // 1
      logic ovf_flag;          // 0
   } tcu_timer_ctl_t;

   typedef struct packed {
      logic [1:0] cap_edge;    // 15:14
      logic [1:0] cap_sel;     // 13:12 capture_input_select
      logic [2:0] rsvd;        // 11:9
      logic cap_mode;          // 8
      logic [2:0] out_mode;    // 7:5
      logic ie;                // 4
      logic cap_in;            // 3, read only
      logic out_bit;           // 2
      logic cap_ovf;           // 1
      logic flag;              // 0
   } tcu_unit_ctl_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [TCU_ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } tcu_apb_req_t;
endpackage : tcu_pkg

// file: sim/tcu_timer_monitor.sv
// Port-level assertions for the capture/compare timer
`timescale 1ns/1ns
module tcu_timer_monitor (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire tcu_pkg::tcu_apb_req_t apb_req, // APB request
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic external_timer_clock_pin, // Pin clock
   input wire logic aux_clock, // Aux clock
   input wire logic [tcu_pkg::TCU_UNITS-1:0] event_in, // Events
   input wire logic [tcu_pkg::TCU_UNITS-1:0] unit_out, // Outputs
   input wire logic irq_unit0, // Unit 0 interrupt
   input wire logic irq_shared // Shared interrupt
);
   import tcu_pkg::*;
   logic acc;
   logic rd_vec;
   logic vec_setup;
   logic mapped;
   logic [8:0] ix;
   assign ix = apb_req.paddr[10:2];
   assign acc = apb_req.psel && apb_req.penable;
   assign rd_vec = !apb_req.pwrite && ix == TCU_IDX_VECTOR && apb_req.paddr[1:0] == 2'h0;
   assign vec_setup = apb_req.psel && !apb_req.penable && rd_vec;
   // Two reserved holes sit inside the unit range
   assign mapped = apb_req.paddr[1:0] == 2'h0 && (ix == TCU_IDX_VECTOR ||
      (ix >= TCU_IDX_TIMER_CTL && ix <= TCU_IDX_UNIT4_VAL && !ix[0] && ix != 9'h16c &&
      ix != 9'h16e));
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   bus_ready_a: assert property (acc |-> pready)
      else $error("access phase without ready");
   upper_zero_a: assert property (acc && !apb_req.pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   hole_err_a: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access without error");
   mapped_ok_a: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access flagged as error");
   idle_quiet_a: assert property (!apb_req.psel |-> !pslverr)
      else $error("error outside a transfer");
   err_data_a: assert property (acc && pslverr && !apb_req.pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   vec_even_a: assert property (acc && rd_vec |-> !prdata[0] && prdata[15:0] <= TCU_VEC_OVERFLOW)
      else $error("vector word not an even offset");
   vec_pending_a: assert property (vec_setup |=> (prdata[15:0] != 16'h0000) == $past(irq_shared))
      else $error("vector word disagrees with shared interrupt");
   irq_drop_a: assert property ($fell(irq_shared) |-> $past(acc && (apb_req.pwrite || rd_vec)))
      else $error("shared interrupt dropped without software");
   unit0_drop_a: assert property ($fell(irq_unit0) |-> $past(acc && apb_req.pwrite))
      else $error("unit 0 interrupt dropped without a write");
   cover property (vec_setup ##1 prdata[15:0] == TCU_VEC_OVERFLOW);
   cover property ($rose(irq_unit0));
   cover property ($changed(unit_out));
endmodule : tcu_timer_monitor

// file: sim/tcu_pins_model.sv
// Far-side pins: timer clocks, capture events and output watchers
`timescale 1ns/1ns
module tcu_pins_model (
   input wire logic pclk, // Bench clock
   input wire logic [4:0] unit_out, // Output stage pins
   output logic ext_pin, // External timer clock
   output logic aux_clk, // Auxiliary clock
   output logic [4:0] event_in // Capture inputs
);
   logic [7:0] phase = 8'h00;
   logic ext_run = 1'b0;
   logic [4:0] last_out = 5'h00;
   int toggles [5] = '{0, 0, 0, 0, 0};
   // Periods divide 64 so a 64-cycle window holds a fixed edge count
   assign aux_clk = phase[3];
   assign ext_pin = ext_run & phase[2];
   initial event_in = 5'h00;
   always @(posedge pclk) begin
      phase <= phase + 8'h01;
      last_out <= unit_out;
      for (int i = 0; i < 5; i++) begin
         if (unit_out[i] !== last_out[i]) begin
            toggles[i] <= toggles[i] + 1;
         end
      end
   end
   // Edge, then room for the two-stage sync and the capture
   task set_event(input int i, input logic v);
      @(posedge pclk);
      event_in[i] <= v;
      repeat (6) @(posedge pclk);
   endtask : set_event
endmodule : tcu_pins_model

// file: sim/tcu_timer_bench.sv
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ns
module tcu_timer_bench;
   import tcu_pkg::*;
   typedef struct packed {
      logic [1:0] src;
      logic [1:0] div;
      logic [15:0] step;
   } tcu_row_t;
   tcu_row_t rows [6] = '{'{2'h2, 2'h0, 16'd64}, '{2'h3, 2'h1, 16'd32}, '{2'h2, 2'h2, 16'd16},
      '{2'h2, 2'h3, 16'd8}, '{2'h1, 2'h0, 16'd4}, '{2'h0, 2'h0, 16'd8}};
   logic [1:0] mds [2] = '{TCU_MODE_UPDOWN, TCU_MODE_UP};
   logic [15:0] vecs [3] = '{TCU_VEC_STEP, TCU_VEC_OVERFLOW, TCU_VEC_NONE};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   tcu_apb_req_t apb_req = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ext_pin;
   logic aux_clk;
   logic [TCU_UNITS-1:0] event_in;
   logic [TCU_UNITS-1:0] unit_out;
   logic irq_unit0;
   logic irq_shared;
   logic [15:0] rd;
   logic [15:0] v1;
   logic er;
   int cyc = 0;
   int c0;
   int t0;
   int mismatches = 0;
   int comparisons = 0;
   tcu_timer u_tcu_timer (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .external_timer_clock_pin(ext_pin),
      .aux_clock(aux_clk), .event_in(event_in), .unit_out(unit_out), .irq_unit0(irq_unit0),
      .irq_shared(irq_shared));
   tcu_pins_model u_tcu_pins_model (.pclk(pclk), .unit_out(unit_out), .ext_pin(ext_pin),
      .aux_clk(aux_clk), .event_in(event_in));
   always #5 pclk = ~pclk;
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   // The run needs about 800 cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   task apb(input logic w, input logic [10:0] a, input logic [15:0] d);
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {16'h0000, d}};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata[15:0];
      er = pslverr;
      apb_req <= '0;
   endtask : apb
   task wr(input logic [8:0] ix, input logic [15:0] d);
      apb(1'b1, {ix, 2'b00}, d);
   endtask : wr
   task rg(input logic [8:0] ix);
      apb(1'b0, {ix, 2'b00}, 16'h0000);
   endtask : rg
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rg(TCU_IDX_VECTOR);
      check("vector at reset", rd, TCU_VEC_NONE);
      rg(TCU_IDX_TIMER_CTL);
      check("control at reset", rd, TCU_TIMER_CTL_RST);
      u_tcu_pins_model.ext_run <= 1'b1;
      // Reads 64 cycles apart in continuous mode
      foreach (rows[i]) begin
         wr(TCU_IDX_TIMER_CTL, {6'h00, rows[i].src, rows[i].div, TCU_MODE_CONT, 4'h4});
         rg(TCU_IDX_COUNT);
         v1 = rd;
         repeat (61) @(posedge pclk);
         rg(TCU_IDX_COUNT);
         check("count step", rd - v1, rows[i].step);
      end
      wr(TCU_IDX_TIMER_CTL, 16'h0200);
      wr(TCU_IDX_COUNT, 16'h0777);
      repeat (8) @(posedge pclk);
      rg(TCU_IDX_COUNT);
      check("halted count", rd, 16'h0777);
      wr(TCU_IDX_UNIT3_CTL, {TCU_EDGE_RISE, TCU_CIS_EVENT, 12'h100});
      u_tcu_pins_model.set_event(3, 1'b1);
      rg(TCU_IDX_UNIT3_VAL);
      check("captured count", rd, 16'h0777);
      rg(TCU_IDX_UNIT3_CTL);
      check("capture flag", {15'h0, rd[0]}, 16'h0001);
      for (int e = 1; e < 4; e++) begin
         for (int lv = 1; lv >= 0; lv--) begin
            wr(TCU_IDX_UNIT4_CTL, {e[1:0], TCU_CIS_EVENT, 12'h100});
            u_tcu_pins_model.set_event(4, lv[0]);
            rg(TCU_IDX_UNIT4_CTL);
            check("edge select", {15'h0, rd[0]}, {15'h0, lv ? e[0] : e[1]});
         end
      end
      // Parking on select 2, a constant zero, first makes the switch to 3 a rising edge
      for (int s = 1; s < 4; s++) begin
         wr(TCU_IDX_UNIT1_CTL, {TCU_EDGE_RISE, 2'h2, 12'h100});
         wr(TCU_IDX_UNIT1_CTL, {TCU_EDGE_RISE, s[1:0], 12'h100});
         repeat (40) @(posedge pclk);
         rg(TCU_IDX_UNIT1_CTL);
         check("capture source", {15'h0, rd[0]}, {15'h0, s != 2});
      end
      wr(TCU_IDX_UNIT0_VAL, 16'h0004);
      wr(TCU_IDX_UNIT1_VAL, 16'h0002);
      wr(TCU_IDX_UNIT0_CTL, 16'h0010);
      wr(TCU_IDX_UNIT1_CTL, 16'h0090);
      foreach (mds[m]) begin
         wr(TCU_IDX_TIMER_CTL, {8'h02, 2'h0, mds[m], 4'h6});
         repeat (4) begin
            rg(TCU_IDX_COUNT);
            check("count within period", {15'h0, rd > 16'h0004}, 16'h0000);
         end
         // Start the toggle window only once the new period has settled
         c0 = cyc;
         t0 = u_tcu_pins_model.toggles[1];
      end
      repeat (40) @(posedge pclk);
      t0 = u_tcu_pins_model.toggles[1] - t0;
      check("toggle rate", {15'h0, t0 * 5 + 6 > cyc - c0 && t0 * 5 < cyc - c0 + 6}, 16'h0001);
      check("unit0 interrupt", {15'h0, irq_unit0}, 16'h0001);
      check("shared interrupt", {15'h0, irq_shared}, 16'h0001);
      // Writing the flag bit as one keeps the overflow pending for the vector walk
      wr(TCU_IDX_TIMER_CTL, 16'h0203);
      foreach (vecs[i]) begin
         rg(TCU_IDX_VECTOR);
         check("vector word", rd, vecs[i]);
      end
      apb(1'b1, {9'h16c, 2'b00}, 16'h5555);
      check("reserved write", {15'h0, er}, 16'h0001);
      apb(1'b0, {TCU_IDX_COUNT, 2'b10}, 16'h0000);
      check("unaligned read", {rd[14:0], er}, 16'h0001);
      wr(TCU_IDX_VECTOR, 16'hffff);
      rg(TCU_IDX_VECTOR);
      check("read-only vector", rd, TCU_VEC_NONE);
      wr(TCU_IDX_UNIT2_CTL, 16'h0004);
      repeat (2) @(posedge pclk);
      check("free output bit", {15'h0, unit_out[2]}, 16'h0001);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check("pins in reset", {11'h0, unit_out}, 16'h0000);
      rg(TCU_IDX_UNIT3_VAL);
      check("value after reset", rd, TCU_UNIT_VAL_RST);
      print_verdict();
   end
endmodule : tcu_timer_bench
bind tcu_timer tcu_timer_monitor u_tcu_timer_monitor (.pclk(pclk), .presetn(presetn),
   .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .external_timer_clock_pin(external_timer_clock_pin), .aux_clock(aux_clock),
   .event_in(event_in), .unit_out(unit_out), .irq_unit0(irq_unit0), .irq_shared(irq_shared));
